/* File: rtl/ejs_top.sv */
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module ejs_top #(
	parameter int SWITCH_DELAY = ejs_pkg::SWITCH_CYCLES,
	parameter int LEAK_W = 16,
	parameter int RATING_W = 8
) (
	input wire logic CLK, // clock, 20 MHz
	input wire logic RESET, // sync reset, high
	input wire logic HSEL, // slave select
	input wire logic [31:0] HADDR, // byte address
	input wire logic [1:0] HTRANS, // transfer type
	input wire logic HWRITE, // write when high
	input wire logic [2:0] HSIZE, // word only
	input wire logic [31:0] HWDATA, // write data
	input wire logic HREADY, // bus ready
	input wire logic [7:0] PD_OUT0, // controller output byte 0
	output logic [31:0] HRDATA, // read data
	output logic HREADYOUT, // slave ready
	output logic HRESP, // always OKAY
	output logic [7:0] PD_IN0, // status byte
	output logic [7:0] PD_IN1, // short measure word
	output logic [7:0] PD_IN2, // wide word high byte
	output logic [7:0] PD_IN3, // wide word low byte
	output logic [7:0] ERROR_CODE // active error code
);
	import ejs_pkg::*;

	localparam int CNT_W = $clog2(SWITCH_DELAY + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SWITCH_DELAY - 1);

	// bus state
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [7:0] addr_reg;
	logic hready_reg;
	logic [31:0] hrdata_reg;
	logic hresp_reg;

	// software-visible state
	logic cycle_active_reg;
	logic part_present_reg;
	logic supply_bad_reg;
	logic press_bad_reg;
	logic [7:0] inlet_reg;
	logic [15:0] vacuum_reg;
	logic [15:0] evac_reg;
	logic [15:0] intake_pres_reg;
	logic [RATING_W-1:0] intake_perf_reg;
	logic intake_known_reg;
	logic [15:0] thr_upper_reg;
	logic [15:0] thr_lower_reg;
	logic [7:0] volt_reg;
	logic [15:0] air_reg;
	logic [N_ERR-1:0] err_flags_reg;

	// selector path
	logic [1:0] sel_meta_reg;
	logic [1:0] sel_sync_reg;
	logic [1:0] sel_seen_reg;
	ejs_sel_e applied_sel_reg;
	logic [CNT_W-1:0] settle_reg;

	// process data out
	logic [7:0] pd0_reg;
	logic [7:0] pd1_reg;
	logic [7:0] pd2_reg;
	logic [7:0] pd3_reg;
	logic [7:0] err_code_reg;

	ejs_stat_if st ();

	// address phase
	wire bus_take = HSEL && HTRANS[1] && HREADY;
	wire take_wr = bus_take && HWRITE;
	wire take_rd = bus_take && !HWRITE;

	// data-phase write decode
	wire wr_cycle = wr_pend_reg && (addr_reg == OFS_CYCLE);
	wire wr_event = wr_pend_reg && (addr_reg == OFS_CM_EVENT);
	wire wr_press = wr_pend_reg && (addr_reg == OFS_PRESSURES);
	wire wr_evac = wr_pend_reg && (addr_reg == OFS_EVAC);
	wire wr_leak = wr_pend_reg && (addr_reg == OFS_LEAK);
	wire wr_intake = wr_pend_reg && (addr_reg == OFS_INTAKE);
	wire wr_thresh = wr_pend_reg && (addr_reg == OFS_THRESH);
	wire wr_supply = wr_pend_reg && (addr_reg == OFS_SUPPLY);
	wire wr_errors = wr_pend_reg && (addr_reg == OFS_ERRORS);

	wire cycle_start = wr_cycle && HWDATA[0];
	wire cycle_end = wr_cycle && HWDATA[1] && !HWDATA[0];
	wire [3:0] event_set = wr_event ? HWDATA[3:0] : 4'h0;
	wire leak_valid = wr_leak && (cycle_active_reg || cycle_start);

	// leakage averages
	wire [LEAK_W-1:0] leak_avg;
	wire [RATING_W-1:0] quality_avg;

	ejs_mavg #(
		.W(LEAK_W),
		.SHIFT(MAVG_SHIFT)
	) u_leak_avg (
		.clk(CLK),
		.reset(RESET),
		.clear(cycle_start),
		.sample_valid(leak_valid),
		.sample(HWDATA[LEAK_W-1:0]),
		.avg(leak_avg)
	);

	ejs_mavg #(
		.W(RATING_W),
		.SHIFT(MAVG_SHIFT)
	) u_quality_avg (
		.clk(CLK),
		.reset(RESET),
		.clear(cycle_start),
		.sample_valid(leak_valid),
		.sample(HWDATA[16 +: RATING_W]),
		.avg(quality_avg)
	);

	ejs_status u_status (
		.clk(CLK),
		.reset(RESET),
		.cycle_start(cycle_start),
		.suction_active(cycle_active_reg),
		.event_set(event_set),
		.supply_bad(supply_bad_reg),
		.press_bad(press_bad_reg),
		.intake_strobe(wr_intake),
		.intake_value(HWDATA[15:0]),
		.thr_upper(thr_upper_reg),
		.thr_lower(thr_lower_reg),
		.err_flags(err_flags_reg),
		.st(st)
	);

	// register read mux
	wire [31:0] rd_cycle = {29'h0, part_present_reg, 1'b0, cycle_active_reg};
	wire [31:0] rd_event = {24'h0, st.warnings};
	wire [31:0] rd_press = {vacuum_reg, 8'h00, inlet_reg};
	wire [31:0] rd_leak = {8'h00, 8'(quality_avg), 16'(leak_avg)};
	wire [31:0] rd_intake = {intake_known_reg, 7'h00, 8'(intake_perf_reg), intake_pres_reg};
	wire [31:0] rd_status = {16'h0000, st.err_code, 2'b00, 1'(applied_sel_reg != SEL_BASIC),
		applied_sel_reg, st.light};
	wire [31:0] rdata_mux =
		(addr_reg == OFS_CYCLE) ? rd_cycle :
		(addr_reg == OFS_CM_EVENT) ? rd_event :
		(addr_reg == OFS_PRESSURES) ? rd_press :
		(addr_reg == OFS_EVAC) ? {16'h0000, evac_reg} :
		(addr_reg == OFS_LEAK) ? rd_leak :
		(addr_reg == OFS_INTAKE) ? rd_intake :
		(addr_reg == OFS_THRESH) ? {thr_lower_reg, thr_upper_reg} :
		(addr_reg == OFS_SUPPLY) ? {air_reg, 8'h00, volt_reg} :
		(addr_reg == OFS_ERRORS) ? {25'h0, err_flags_reg} :
		(addr_reg == OFS_STATUS) ? rd_status : 32'h0000_0000;

	// pair contents follow the applied selector only
	wire [7:0] leak_byte = (leak_avg > LEAK_W'(8'hFF)) ? 8'hFF : leak_avg[7:0];
	wire [15:0] intake_shown = intake_known_reg ? intake_pres_reg : UNKNOWN_VALUE;
	wire [7:0] short_measure_word =
		(applied_sel_reg == SEL_BASIC) ? inlet_reg :
		(applied_sel_reg == SEL_WARN) ? st.warnings :
		(applied_sel_reg == SEL_LEAK) ? leak_byte : volt_reg;
	wire [15:0] wide_measure_word =
		(applied_sel_reg == SEL_BASIC) ? vacuum_reg :
		(applied_sel_reg == SEL_WARN) ? evac_reg :
		(applied_sel_reg == SEL_LEAK) ? intake_shown : air_reg;
	wire pair_select_ack = (applied_sel_reg != SEL_BASIC);
	wire [7:0] pd0_next = {pair_select_ack, 3'b000, st.light, part_present_reg};

	// selector settling
	wire sel_moved = (sel_sync_reg != sel_seen_reg);
	wire sel_differs = (sel_sync_reg != applied_sel_reg);
	wire sel_apply = !sel_moved && sel_differs && (settle_reg == CNT_LAST);

	// bus slave
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hready_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
			hresp_reg <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= take_wr;
			rd_pend_reg <= take_rd;
			hresp_reg <= 1'b0;
			if (bus_take)
				addr_reg <= {HADDR[7:2], 2'b00};
			if (take_rd)
				hready_reg <= 1'b0;
			else if (rd_pend_reg)
				hready_reg <= 1'b1;
			if (rd_pend_reg)
				hrdata_reg <= rdata_mux;
		end
	end

	// suction cycle and level flags
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			cycle_active_reg <= 1'b0;
			part_present_reg <= 1'b0;
			supply_bad_reg <= 1'b0;
			press_bad_reg <= 1'b0;
		end
		else
		begin
			if (cycle_start)
				cycle_active_reg <= 1'b1;
			else if (cycle_end)
				cycle_active_reg <= 1'b0;
			if (wr_cycle)
				part_present_reg <= HWDATA[2];
			if (wr_event)
			begin
				supply_bad_reg <= HWDATA[WARN_SUPPLY];
				press_bad_reg <= HWDATA[WARN_PRESS];
			end
		end
	end

	// measurement words shown in the pair field
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			inlet_reg <= 8'h00;
			vacuum_reg <= 16'h0000;
			evac_reg <= 16'h0000;
			volt_reg <= 8'h00;
			air_reg <= 16'h0000;
		end
		else
		begin
			if (wr_press)
			begin
				inlet_reg <= HWDATA[7:0];
				vacuum_reg <= HWDATA[31:16];
			end
			if (wr_evac)
				evac_reg <= HWDATA[15:0];
			if (wr_supply)
			begin
				volt_reg <= HWDATA[7:0];
				air_reg <= HWDATA[31:16];
			end
		end
	end

	// thresholds and error levels
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			thr_upper_reg <= 16'h0000;
			thr_lower_reg <= 16'h0000;
			err_flags_reg <= '0;
		end
		else
		begin
			if (wr_thresh)
			begin
				thr_upper_reg <= HWDATA[15:0];
				thr_lower_reg <= HWDATA[31:16];
			end
			if (wr_errors)
				err_flags_reg <= HWDATA[N_ERR-1:0];
		end
	end

	// free-intake values, unknown until first measurement
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			intake_pres_reg <= 16'h0000;
			intake_perf_reg <= '0;
			intake_known_reg <= 1'b0;
		end
		else if (wr_intake)
		begin
			intake_pres_reg <= HWDATA[15:0];
			intake_perf_reg <= HWDATA[16 +: RATING_W];
			intake_known_reg <= 1'b1;
		end
	end

	// selector synchroniser and settle counter
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			sel_meta_reg <= 2'b00;
			sel_sync_reg <= 2'b00;
			sel_seen_reg <= 2'b00;
			settle_reg <= '0;
			applied_sel_reg <= SEL_BASIC;
		end
		else
		begin
			sel_meta_reg <= PD_OUT0[PDO0_SEL_LSB +: 2];
			sel_sync_reg <= sel_meta_reg;
			sel_seen_reg <= sel_sync_reg;
			if (sel_moved || !sel_differs || sel_apply)
				settle_reg <= '0;
			else
				settle_reg <= settle_reg + 1'b1;
			if (sel_apply)
				applied_sel_reg <= ejs_sel_e'(sel_sync_reg);
		end
	end

	// process data input bytes; contents and acknowledge share one edge
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			pd0_reg <= {4'h0, LIGHT_GREEN, 1'b0};
			pd1_reg <= 8'h00;
			pd2_reg <= 8'h00;
			pd3_reg <= 8'h00;
			err_code_reg <= CODE_NONE;
		end
		else
		begin
			pd0_reg <= pd0_next;
			pd1_reg <= short_measure_word;
			pd2_reg <= wide_measure_word[15:8];
			pd3_reg <= wide_measure_word[7:0];
			err_code_reg <= st.err_code;
		end
	end

	assign HRDATA = hrdata_reg;
	assign HREADYOUT = hready_reg;
	assign HRESP = hresp_reg;
	assign PD_IN0 = pd0_reg;
	assign PD_IN1 = pd1_reg;
	assign PD_IN2 = pd2_reg;
	assign PD_IN3 = pd3_reg;
	assign ERROR_CODE = err_code_reg;
endmodule

/* File: rtl/ejs_pkg.sv */
package ejs_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SWITCH_TIME_NS = 1000;
	localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAVG_SHIFT = 3;

	localparam logic [7:0] OFS_CYCLE = 8'h00;
	localparam logic [7:0] OFS_CM_EVENT = 8'h04;
	localparam logic [7:0] OFS_PRESSURES = 8'h08;
	localparam logic [7:0] OFS_EVAC = 8'h0C;
	localparam logic [7:0] OFS_LEAK = 8'h10;
	localparam logic [7:0] OFS_INTAKE = 8'h14;
	localparam logic [7:0] OFS_THRESH = 8'h18;
	localparam logic [7:0] OFS_SUPPLY = 8'h1C;
	localparam logic [7:0] OFS_ERRORS = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	localparam int WARN_VALVE = 0;
	localparam int WARN_EVAC = 1;
	localparam int WARN_LEAK = 2;
	localparam int WARN_UPPER = 3;
	localparam int WARN_INTAKE = 4;
	localparam int WARN_SUPPLY = 5;
	localparam int WARN_SPARE = 6;
	localparam int WARN_PRESS = 7;

	localparam int N_ERR = 7;
	localparam int ERR_DATA = 0;
	localparam int ERR_COMM = 1;
	localparam int ERR_ZERO = 2;
	localparam int ERR_VLOW = 3;
	localparam int ERR_LINK = 4;
	localparam int ERR_VHIGH = 5;
	localparam int ERR_PRESS = 6;
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_E01 = 8'h01;
	localparam logic [7:0] CODE_E02 = 8'h02;
	localparam logic [7:0] CODE_E03 = 8'h03;
	localparam logic [7:0] CODE_E07 = 8'h07;
	localparam logic [7:0] CODE_E08 = 8'h08;
	localparam logic [7:0] CODE_E17 = 8'h11;
	localparam logic [7:0] CODE_E18 = 8'h12;

	localparam logic [2:0] LIGHT_GREEN = 3'h1;
	localparam logic [2:0] LIGHT_YELLOW = 3'h2;
	localparam logic [2:0] LIGHT_RED = 3'h4;

	localparam int PDI0_PRESENT_BIT = 0;
	localparam int PDI0_LIGHT_LSB = 1;
	localparam int PDI0_ACK_BIT = 7;
	localparam int PDO0_SEL_LSB = 4;
	localparam logic [15:0] UNKNOWN_VALUE = 16'hFFFF;

	typedef enum logic [1:0] {
		SEL_BASIC = 2'b00,
		SEL_WARN = 2'b01,
		SEL_LEAK = 2'b10,
		SEL_SUPPLY = 2'b11
	} ejs_sel_e;
endpackage

/* File: rtl/ejs_stat_if.sv */
`timescale 1ns/1ns
interface ejs_stat_if;
	logic [7:0] warnings;
	logic [2:0] light;
	logic [7:0] err_code;
	modport src (output warnings, output light, output err_code);
	modport dst (input warnings, input light, input err_code);
endinterface

/* File: rtl/ejs_mavg.sv */
`timescale 1ns/1ns
module ejs_mavg #(
	parameter int W = 16,
	parameter int SHIFT = ejs_pkg::MAVG_SHIFT
) (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	input wire logic clear, // cycle start
	input wire logic sample_valid, // new sample
	input wire logic [W-1:0] sample, // sample value
	output logic [W-1:0] avg // averaged value
);
	import ejs_pkg::*;
	logic first_reg;
	logic signed [W:0] diff;
	logic signed [W:0] step;
	logic [W-1:0] avg_next;
	logic first_next;

	assign diff = $signed({1'b0, sample}) - $signed({1'b0, avg});
	assign step = diff >>> SHIFT;

	always_comb
	begin
		avg_next = avg;
		first_next = first_reg;
		if (clear)
		begin
			avg_next = '0;
			first_next = 1'b1;
		end
		if (sample_valid)
		begin
			avg_next = (first_reg || clear) ? sample : W'(avg + step[W-1:0]);
			first_next = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			avg <= '0;
			first_reg <= 1'b1;
		end
		else
		begin
			avg <= avg_next;
			first_reg <= first_next;
		end
	end
endmodule

/* File: rtl/ejs_status.sv */
`timescale 1ns/1ns
module ejs_status (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	input wire logic cycle_start, // suction cycle begins
	input wire logic suction_active, // suction running
	input wire logic [3:0] event_set, // per-cycle events
	input wire logic supply_bad, // supply out of range
	input wire logic press_bad, // system pressure out of range
	input wire logic intake_strobe, // new intake measurement
	input wire logic [15:0] intake_value, // intake pressure
	input wire logic [15:0] thr_upper, // upper threshold
	input wire logic [15:0] thr_lower, // release level
	input wire logic [ejs_pkg::N_ERR-1:0] err_flags, // active errors
	ejs_stat_if.src st // status out
);
	import ejs_pkg::*;
	logic [3:0] cyc_warn_reg;
	logic intake_warn_reg;
	logic [3:0] cyc_warn_next;
	logic [3:0] ev_gated;
	logic [7:0] warn_word;
	logic [7:0] code_sel;
	logic [2:0] light_sel;

	assign ev_gated = (suction_active || cycle_start) ? event_set : 4'h0;
	assign cyc_warn_next = (cycle_start ? 4'h0 : cyc_warn_reg) | ev_gated;

	assign warn_word = {press_bad, 1'b0, supply_bad, intake_warn_reg, cyc_warn_reg};

	assign light_sel = (|err_flags) ? LIGHT_RED :
		(|warn_word) ? LIGHT_YELLOW : LIGHT_GREEN;

	assign code_sel = err_flags[ERR_DATA] ? CODE_E01 :
		err_flags[ERR_COMM] ? CODE_E02 :
		err_flags[ERR_ZERO] ? CODE_E03 :
		err_flags[ERR_VLOW] ? CODE_E07 :
		err_flags[ERR_LINK] ? CODE_E08 :
		err_flags[ERR_VHIGH] ? CODE_E17 :
		err_flags[ERR_PRESS] ? CODE_E18 : CODE_NONE;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cyc_warn_reg <= 4'h0;
			intake_warn_reg <= 1'b0;
			st.warnings <= 8'h00;
			st.light <= LIGHT_GREEN;
			st.err_code <= CODE_NONE;
		end
		else
		begin
			cyc_warn_reg <= cyc_warn_next;
			if (intake_strobe)
				intake_warn_reg <= (intake_value > thr_lower) && (intake_value < thr_upper);
			st.warnings <= warn_word;
			st.light <= light_sel;
			st.err_code <= code_sel;
		end
	end
endmodule

/* File: testbench/ejs_top_sva.sv */
`timescale 1ns/1ns
module ejs_top_sva
	import ejs_pkg::*;
#(
	parameter int SWITCH_DELAY = 20
) (
	input wire logic CLK, // clock
	input wire logic RESET, // sync reset
	input wire logic HSEL, // slave select
	input wire logic [1:0] HTRANS, // transfer type
	input wire logic HWRITE, // write
	input wire logic HREADY, // bus ready
	input wire logic [7:0] PD_OUT0, // controller byte
	input wire logic HREADYOUT, // slave ready
	input wire logic HRESP, // response
	input wire logic [7:0] PD_IN0, // status byte
	input wire logic [7:0] ERROR_CODE // error code
);
	logic [1:0] sel_q;
	int unsigned calm_cnt;
	wire logic bus_take = HSEL && HTRANS[1] && HREADY;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	// cycles the selector has sat unchanged
	always_ff @(posedge CLK)
	begin
		sel_q <= PD_OUT0[5:4];
		if (RESET || PD_OUT0[5:4] != sel_q)
			calm_cnt <= 0;
		else
			calm_cnt <= calm_cnt + 1;
	end

	AST_LIGHT_ONEHOT: assert property ($onehot(PD_IN0[3:1]))
		else $error("light field not one-hot");
	AST_PD0_SPARE: assert property (PD_IN0[6:4] == 3'h0)
		else $error("spare status bits set");
	AST_RED_ON_ERROR: assert property ((ERROR_CODE != 8'h00) [*4] |-> PD_IN0[3:1] == LIGHT_RED)
		else $error("error active but light not red");
	AST_NO_RED_IDLE: assert property ((ERROR_CODE == 8'h00) [*4] |-> PD_IN0[3:1] != LIGHT_RED)
		else $error("red light without error");
	AST_ACK_RISE: assert property ($rose(PD_IN0[7]) |-> $past(PD_OUT0[5:4], 3) != 2'b00)
		else $error("ack rose without pair request");
	AST_ACK_FALL: assert property ($fell(PD_IN0[7]) |-> $past(PD_OUT0[5:4], 3) == 2'b00)
		else $error("ack fell while pair requested");
	AST_ACK_FOLLOWS: assert property (calm_cnt > SWITCH_DELAY + 6 |-> PD_IN0[7] == (sel_q != 2'b00))
		else $error("ack does not follow settled selector");
	AST_READ_WAIT: assert property (bus_take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	AST_WRITE_NOWAIT: assert property (bus_take && HWRITE |=> HREADYOUT)
		else $error("write stalled");
	AST_HRESP_OKAY: assert property (HRESP == 1'b0)
		else $error("response not okay");
endmodule

bind ejs_top ejs_top_sva #(.SWITCH_DELAY(SWITCH_DELAY)) u_sva (.CLK(CLK), .RESET(RESET),
	.HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .PD_OUT0(PD_OUT0),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .PD_IN0(PD_IN0), .ERROR_CODE(ERROR_CODE));

/* File: testbench/ejs_ctrl_model.sv */
`timescale 1ns/1ns
module ejs_ctrl_model (
	input wire logic clk, // clock
	input wire logic [7:0] pd_in0, // status byte
	input wire logic [7:0] pd_in1, // short word
	input wire logic [7:0] pd_in2, // wide high
	input wire logic [7:0] pd_in3, // wide low
	output logic [7:0] pd_out0 // cyclic output byte 0
);
	initial pd_out0 = 8'h00;

	// one pair fetch; lag holds the pair before returning to 00
	task automatic fetch(input logic [1:0] sel, input int lag, output logic [7:0] v8,
		output logic [15:0] v16, output logic ack);
		int n;
		pd_out0 <= {2'b00, sel, 4'h0};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while ((pd_in0[7] !== (sel != 2'b00) || n < 2) && n < 40);
		ack = pd_in0[7];
		v8 = pd_in1;
		v16 = {pd_in2, pd_in3};
		repeat (lag) @(posedge clk);
		pd_out0 <= 8'h00;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pd_in0[7] !== 1'b0 && n < 40);
	endtask
endmodule

/* File: testbench/ejs_top_tb.sv */
`timescale 1ns/1ns
module ejs_top_tb;
	import ejs_pkg::*;
	localparam int SW_DLY = 2;
	localparam logic [7:0] CODES [7] = '{CODE_E01, CODE_E02, CODE_E03, CODE_E07, CODE_E08,
		CODE_E17, CODE_E18};
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'b00;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA, rdv;
	logic HREADYOUT, HRESP, ack;
	logic [7:0] PD_OUT0, PD_IN0, PD_IN1, PD_IN2, PD_IN3, ERROR_CODE, v8;
	logic [15:0] v16;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;

	always #25 CLK = ~CLK;

	ejs_top #(.SWITCH_DELAY(SW_DLY)) dut (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .PD_OUT0(PD_OUT0), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .PD_IN0(PD_IN0), .PD_IN1(PD_IN1), .PD_IN2(PD_IN2), .PD_IN3(PD_IN3),
		.ERROR_CODE(ERROR_CODE));

	ejs_ctrl_model u_ctrl (.clk(CLK), .pd_in0(PD_IN0), .pd_in1(PD_IN1), .pd_in2(PD_IN2),
		.pd_in3(PD_IN3), .pd_out0(PD_OUT0));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	// single word transfer, entered just after a clock edge
	task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {24'h0, ofs};
		HWRITE <= wr;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rdv = HRDATA;
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		bus(1'b1, ofs, d);
	endtask

	task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
		bus(1'b0, ofs, 32'h0);
		chk(rdv, exp);
	endtask

	task automatic pair(input logic [1:0] sel, input int lag, input logic [7:0] e8,
		input logic [15:0] e16);
		u_ctrl.fetch(sel, lag, v8, v16, ack);
		chk(ack, sel != 2'b00);
		chk(v8, e8);
		chk(v16, e16);
	endtask

	initial
	begin
		repeat (8) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		chk(PD_IN0, 8'h02);
		chk(ERROR_CODE, CODE_NONE);
		rdc(OFS_STATUS, {29'h0, LIGHT_GREEN});
		pair(2'b10, 0, 8'h00, UNKNOWN_VALUE);
		wr(OFS_PRESSURES, 32'h1234_005A);
		pair(2'b00, 0, 8'h5A, 16'h1234);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_CYCLE, 32'h1);
			wr(OFS_CM_EVENT, 32'h1 << i);
			rdc(OFS_CM_EVENT, 32'h1 << i);
			chk(PD_IN0[3:1], LIGHT_YELLOW);
		end
		wr(OFS_CYCLE, 32'h2);
		wr(OFS_CM_EVENT, 32'h0F);
		rdc(OFS_CM_EVENT, 32'h08);
		wr(OFS_CM_EVENT, 32'hE0);
		rdc(OFS_CM_EVENT, 32'hA8);
		wr(OFS_THRESH, {16'd200, 16'd600});
		wr(OFS_INTAKE, 32'h0050_0190);
		rdc(OFS_INTAKE, 32'h8050_0190);
		rdc(OFS_CM_EVENT, 32'hB8);
		wr(OFS_INTAKE, 32'h0060_02BC);
		rdc(OFS_CM_EVENT, 32'hA8);
		wr(OFS_CM_EVENT, 32'h0);
		wr(OFS_CYCLE, 32'h1);
		rdc(OFS_LEAK, 32'h0);
		wr(OFS_LEAK, 32'h005A_0028);
		rdc(OFS_LEAK, 32'h005A_0028);
		wr(OFS_LEAK, 32'h0062_0030);
		rdc(OFS_LEAK, 32'h005B_0029);
		wr(OFS_CM_EVENT, 32'h4);
		wr(OFS_EVAC, 32'h0321);
		pair(2'b01, 0, 8'h04, 16'h0321);
		pair(2'b10, 3, 8'h29, 16'h02BC);
		wr(OFS_SUPPLY, 32'h0456_00F0);
		pair(2'b11, 6, 8'hF0, 16'h0456);
		wr(OFS_CYCLE, 32'h1);
		rdc(OFS_LEAK, 32'h0);
		wr(OFS_CM_EVENT, 32'h20);
		for (int i = 0; i < N_ERR; i++)
		begin
			wr(OFS_ERRORS, 32'h1 << i);
			rdc(OFS_STATUS, {16'h0, CODES[i], 8'h04});
			chk(ERROR_CODE, CODES[i]);
			chk(PD_IN0[3:1], LIGHT_RED);
		end
		wr(OFS_ERRORS, 32'h7F);
		rdc(OFS_STATUS, {16'h0, CODE_E01, 8'h04});
		chk(ERROR_CODE, CODE_E01);
		wr(OFS_ERRORS, 32'h0);
		rdc(OFS_STATUS, {16'h0, CODE_NONE, 8'h02});
		wr(OFS_CM_EVENT, 32'h0);
		rdc(OFS_STATUS, {29'h0, LIGHT_GREEN});
		wr(8'h3C, 32'hFFFF_FFFF);
		rdc(8'h3C, 32'h0);
		wrap_up();
	end
endmodule
